// ==== include/tei_pkg.sv ====
// Purpose: Shared constants for the timer and external interrupt input block
// Assumes: AHB-Lite slave, 32-bit word registers, 50 MHz clock
// Notes:   Offsets are byte addresses, one register per aligned word
//
// Behaviour
// - Three 16-bit timers, third counts up/down
// - First gate-select lets irq pin A run timer A
// - Edge select A: falling edge sets flag A
// - Level select A: low pin sets flag A
// - Second gate-select lets irq pin B run timer B
// - Edge select B: falling edge sets flag B
// - Level select B: low pin sets flag B
// - Counter mode A counts count-pin falling edges
// - Counter mode B counts count-pin falling edges
// - Timer C pin is clock in and out
// - Control pin reloads, captures or sets direction
// - Idle halts processor, timers and interrupts run
// - Power-down stops timers, external irq wakes
package tei_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_MASK  = 8'h08;
  localparam logic [7:0] OFF_CNTA  = 8'h0C;
  localparam logic [7:0] OFF_CNTB  = 8'h10;
  localparam logic [7:0] OFF_CNTC  = 8'h14;
  localparam logic [7:0] OFF_RCAPC = 8'h18;
  localparam logic [7:0] OFF_PMODE = 8'h1C;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CB_A_RUN    = 0;
  localparam int unsigned CB_A_GATE   = 1;
  localparam int unsigned CB_A_CTR    = 2;
  localparam int unsigned CB_B_RUN    = 3;
  localparam int unsigned CB_B_GATE   = 4;
  localparam int unsigned CB_B_CTR    = 5;
  localparam int unsigned CB_IRQA_EDG = 6;
  localparam int unsigned CB_IRQB_EDG = 7;
  localparam int unsigned CB_C_RUN    = 8;
  localparam int unsigned CB_C_EXTCLK = 9;
  localparam int unsigned CB_C_CLKOUT = 10;
  localparam int unsigned CB_C_EXEN   = 11;
  localparam int unsigned CB_C_MODE   = 12;
  localparam int unsigned CTRL_W      = 14;
  localparam logic [13:0] CTRL_RST    = 14'h0000;

  localparam logic [1:0] CM_RELOAD  = 2'h0;
  localparam logic [1:0] CM_CAPTURE = 2'h1;
  localparam logic [1:0] CM_UPDOWN  = 2'h2;

  // ---------------------------------------------------------------
  // Status and mask fields
  // ---------------------------------------------------------------
  localparam int unsigned SB_IRQA = 0;
  localparam int unsigned SB_IRQB = 1;
  localparam int unsigned SB_OVFA = 2;
  localparam int unsigned SB_OVFB = 3;
  localparam int unsigned SB_OVFC = 4;
  localparam int unsigned SB_EXC  = 5;
  localparam int unsigned SB_WAKE = 6;
  localparam int unsigned STAT_W  = 7;
  localparam logic [6:0]  STAT_RST = 7'h00;
  localparam logic [6:0]  MASK_RST = 7'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CNT_TOP  = 16'hFFFF;

  // ---------------------------------------------------------------
  // Pin indices and power modes
  // ---------------------------------------------------------------
  localparam int unsigned PIN_IRQA = 0;
  localparam int unsigned PIN_IRQB = 1;
  localparam int unsigned PIN_CNTA = 2;
  localparam int unsigned PIN_CNTB = 3;
  localparam int unsigned PIN_CCLK = 4;
  localparam int unsigned PIN_CCTL = 5;
  localparam int unsigned PIN_W    = 6;
  localparam logic [5:0]  PIN_RST  = 6'h3F;

  localparam logic [1:0] PM_REQ_IDLE = 2'h1;
  localparam logic [1:0] PM_REQ_DOWN = 2'h2;
  localparam int unsigned HTRANS_ACT = 1;

  typedef enum logic [2:0] {
    TEI_PM_RUN  = 3'b001,
    TEI_PM_IDLE = 3'b010,
    TEI_PM_DOWN = 3'b100
  } tei_pm_t;

endpackage : tei_pkg

// ==== hdl/tei_pin_sync.sv ====
// Purpose: Two-stage synchroniser and falling-edge finder for pins
// Assumes: Pins idle high, so reset values are ones
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module tei_pin_sync
  import tei_pkg::*;
(
  input  wire logic              clk_i,   // System clock
  input  wire logic              reset_i, // Synchronous reset
  input  wire logic [PIN_W-1:0]  pin_i,   // Raw pins
  output logic      [PIN_W-1:0]  lvl_o,   // Synchronised level
  output logic      [PIN_W-1:0]  fall_o   // One-cycle falling pulse
);
  import tei_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
  } tei_sync_t;

  tei_sync_t sync_ff;
  tei_sync_t nxt_sync;

  always_comb begin
    nxt_sync    = sync_ff;
    nxt_sync.s1 = pin_i;
    nxt_sync.s2 = sync_ff.s1;
    nxt_sync.s3 = sync_ff.s2;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync_ff <= '{s1: PIN_RST, s2: PIN_RST, s3: PIN_RST};
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  // Edge from two settled samples
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_edge
      assign lvl_o[gi]  = sync_ff.s2[gi];
      assign fall_o[gi] = sync_ff.s3[gi] & ~sync_ff.s2[gi];
    end
  endgenerate

endmodule : tei_pin_sync

// ==== hdl/tei_timer_irq.sv ====
// Purpose: Two general timers, up/down timer C, external irq inputs
// Assumes: AHB-Lite master issues single word transfers only
// Notes:   Every access takes one wait state; response always OKAY
`timescale 1ns/1ps
module tei_timer_irq
  import tei_pkg::*;
(
  input  wire logic        clk_i,              // 50 MHz clock
  input  wire logic        reset_i,            // Sync reset, high
  input  wire logic        hsel_i,             // Slave select
  input  wire logic [31:0] haddr_i,            // Byte address
  input  wire logic [1:0]  htrans_i,           // Transfer type
  input  wire logic        hwrite_i,           // Write when high
  input  wire logic [2:0]  hsize_i,            // Word only
  input  wire logic [31:0] hwdata_i,           // Write data
  input  wire logic        hready_i,           // Bus ready
  output logic      [31:0] hrdata_o,           // Read data
  output logic             hreadyout_o,        // Slave ready
  output logic             hresp_o,            // Always OKAY
  input  wire logic        ext_irq_a_pin_i,    // Ext irq A, gate A
  input  wire logic        ext_irq_b_pin_i,    // Ext irq B, gate B
  input  wire logic        timer_a_count_pin_i, // Count pin A
  input  wire logic        timer_b_count_pin_i, // Count pin B
  input  wire logic        timer_c_clock_pin_i, // Clock pin C in
  output logic             timer_c_clock_pin_o, // Clock pin C out
  output logic             timer_c_clock_pin_oe_o, // Drive enable
  input  wire logic        timer_c_ctrl_pin_i, // Reload/cap/dir
  output logic             irq_o,              // Level interrupt
  output logic             cpu_halt_o,         // Processor frozen
  output logic             periph_clk_en_o,    // Low in power-down
  output logic             wake_o              // Wake pulse
);
  import tei_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] mask;
    logic [15:0]       cnt_a;
    logic [15:0]       cnt_b;
    logic [15:0]       cnt_c;
    logic [15:0]       rcap_c;
    tei_pm_t           pm;
    logic              pend;
    logic              wr;
    logic [7:0]        addr;
    logic              ready;
    logic [31:0]       rdata;
    logic              irq;
    logic              halt;
    logic              clk_en;
    logic              wake;
    logic              cout;
  } tei_state_t;

  tei_state_t st_ff;
  tei_state_t nxt_st;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] lvl;
  logic [PIN_W-1:0] fall;

  assign pin_raw = {timer_c_ctrl_pin_i, timer_c_clock_pin_i,
                    timer_b_count_pin_i, timer_a_count_pin_i,
                    ext_irq_b_pin_i, ext_irq_a_pin_i};

  tei_pin_sync u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (pin_raw),
    .lvl_o   (lvl),
    .fall_o  (fall)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Carry in bit 16 marks overflow
  function automatic logic [16:0] tei_step(input logic [15:0] c,
                                           input logic        en);
    tei_step = en ? ({1'b0, c} + 17'h00001) : {1'b0, c};
  endfunction : tei_step

  // One tick: run bit, optional gate, timer or counter source
  function automatic logic tei_tick(input logic run,
                                    input logic gate,
                                    input logic gate_pin,
                                    input logic ctr,
                                    input logic pin_fall);
    tei_tick = run & (~gate | gate_pin) & (~ctr | pin_fall);
  endfunction : tei_tick

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [STAT_W-1:0] set_v;
  logic [STAT_W-1:0] clr_v;
  logic [16:0]       step_a;
  logic [16:0]       step_b;
  logic              run_ok;
  logic              tick_a;
  logic              tick_b;
  logic              tick_c;
  logic              c_down;
  logic              c_ext;
  logic [1:0]        c_mode;
  logic              wr_now;
  logic              addr_ph;

  always_comb begin
    nxt_st  = st_ff;
    set_v   = '0;
    clr_v   = '0;
    c_mode  = st_ff.ctrl[CB_C_MODE +: 2];
    // Power-down freezes the peripheral clock, so timers hold
    run_ok  = (st_ff.pm != TEI_PM_DOWN);

    // Timers A and B
    tick_a = run_ok & tei_tick(st_ff.ctrl[CB_A_RUN],
                               st_ff.ctrl[CB_A_GATE],
                               lvl[PIN_IRQA],
                               st_ff.ctrl[CB_A_CTR],
                               fall[PIN_CNTA]);
    tick_b = run_ok & tei_tick(st_ff.ctrl[CB_B_RUN],
                               st_ff.ctrl[CB_B_GATE],
                               lvl[PIN_IRQB],
                               st_ff.ctrl[CB_B_CTR],
                               fall[PIN_CNTB]);
    step_a        = tei_step(st_ff.cnt_a, tick_a);
    step_b        = tei_step(st_ff.cnt_b, tick_b);
    nxt_st.cnt_a  = step_a[15:0];
    nxt_st.cnt_b  = step_b[15:0];
    set_v[SB_OVFA] = step_a[16];
    set_v[SB_OVFB] = step_b[16];

    // Timer C: with external clock selected the pin clocks it, unless the pin is driven as output
    tick_c = run_ok & st_ff.ctrl[CB_C_RUN] &
             (~st_ff.ctrl[CB_C_EXTCLK] | st_ff.ctrl[CB_C_CLKOUT] |
              fall[PIN_CCLK]);
    c_down = (c_mode == CM_UPDOWN) & ~lvl[PIN_CCTL];
    c_ext  = run_ok & st_ff.ctrl[CB_C_EXEN] &
             (c_mode != CM_UPDOWN) & fall[PIN_CCTL];
    if (tick_c) begin
      if (c_down) begin
        if (st_ff.cnt_c == st_ff.rcap_c) begin
          nxt_st.cnt_c   = CNT_TOP;
          set_v[SB_OVFC] = 1'b1;
        end else begin
          nxt_st.cnt_c = st_ff.cnt_c - 16'h0001;
        end
      end else if (st_ff.cnt_c == CNT_TOP) begin
        nxt_st.cnt_c   = (c_mode == CM_CAPTURE) ? CNT_RST : st_ff.rcap_c;
        set_v[SB_OVFC] = 1'b1;
      end else begin
        nxt_st.cnt_c = st_ff.cnt_c + 16'h0001;
      end
    end
    if (c_ext) begin
      set_v[SB_EXC] = 1'b1;
      if (c_mode == CM_CAPTURE) begin
        nxt_st.rcap_c = st_ff.cnt_c;
      end else begin
        nxt_st.cnt_c = st_ff.rcap_c;
      end
    end
    // Square wave on the pin, half period per overflow
    if (st_ff.ctrl[CB_C_CLKOUT] & set_v[SB_OVFC]) begin
      nxt_st.cout = ~st_ff.cout;
    end

    // External interrupt flags keep working in every power mode
    set_v[SB_IRQA] = st_ff.ctrl[CB_IRQA_EDG] ? fall[PIN_IRQA]
                                             : ~lvl[PIN_IRQA];
    set_v[SB_IRQB] = st_ff.ctrl[CB_IRQB_EDG] ? fall[PIN_IRQB]
                                             : ~lvl[PIN_IRQB];

    // Bus data phase: write lands one cycle after address phase
    wr_now  = st_ff.pend & st_ff.wr;
    addr_ph = hsel_i & hready_i & htrans_i[HTRANS_ACT];
    nxt_st.ready = 1'b1;
    nxt_st.pend  = 1'b0;
    if (addr_ph) begin
      nxt_st.pend  = 1'b1;
      nxt_st.ready = 1'b0;
      nxt_st.wr    = hwrite_i;
      nxt_st.addr  = haddr_i[7:0];
    end

    // Power modes; wake pulse only for the cycle of exit
    nxt_st.wake = 1'b0;
    case (st_ff.pm)
      TEI_PM_RUN: begin
        if (wr_now && st_ff.addr == OFF_PMODE) begin
          if (hwdata_i[1:0] == PM_REQ_DOWN) begin
            nxt_st.pm = TEI_PM_DOWN;
          end else if (hwdata_i[1:0] == PM_REQ_IDLE) begin
            nxt_st.pm = TEI_PM_IDLE;
          end
        end
      end
      TEI_PM_IDLE: begin
        // Any unmasked event ends idle
        if (|((st_ff.stat | set_v) & st_ff.mask)) begin
          nxt_st.pm      = TEI_PM_RUN;
          nxt_st.wake    = 1'b1;
          set_v[SB_WAKE] = 1'b1;
        end
      end
      TEI_PM_DOWN: begin
        // Only external interrupt pins can wake, mask not needed
        if (set_v[SB_IRQA] | set_v[SB_IRQB]) begin
          nxt_st.pm      = TEI_PM_RUN;
          nxt_st.wake    = 1'b1;
          set_v[SB_WAKE] = 1'b1;
        end
      end
      default: begin
        nxt_st.pm = TEI_PM_RUN;
      end
    endcase

    // Register writes; counter writes override counting
    if (wr_now) begin
      case (st_ff.addr)
        OFF_CTRL:  nxt_st.ctrl   = hwdata_i[CTRL_W-1:0];
        OFF_STAT:  clr_v         = hwdata_i[STAT_W-1:0];
        OFF_MASK:  nxt_st.mask   = hwdata_i[STAT_W-1:0];
        OFF_CNTA:  nxt_st.cnt_a  = hwdata_i[15:0];
        OFF_CNTB:  nxt_st.cnt_b  = hwdata_i[15:0];
        OFF_CNTC:  nxt_st.cnt_c  = hwdata_i[15:0];
        OFF_RCAPC: nxt_st.rcap_c = hwdata_i[15:0];
        default:   clr_v         = '0;
      endcase
    end

    // Set beats a same-cycle write-one clear
    nxt_st.stat = (st_ff.stat & ~clr_v) | set_v;

    // Read data captured in the first data-phase cycle
    nxt_st.rdata = st_ff.rdata;
    if (st_ff.pend) begin
      nxt_st.rdata = 32'h0000_0000;
      if (!st_ff.wr) begin
        case (st_ff.addr)
          OFF_CTRL:  nxt_st.rdata[CTRL_W-1:0] = st_ff.ctrl;
          OFF_STAT:  nxt_st.rdata[STAT_W-1:0] = st_ff.stat;
          OFF_MASK:  nxt_st.rdata[STAT_W-1:0] = st_ff.mask;
          OFF_CNTA:  nxt_st.rdata[15:0]       = st_ff.cnt_a;
          OFF_CNTB:  nxt_st.rdata[15:0]       = st_ff.cnt_b;
          OFF_CNTC:  nxt_st.rdata[15:0]       = st_ff.cnt_c;
          OFF_RCAPC: nxt_st.rdata[15:0]       = st_ff.rcap_c;
          OFF_PMODE: nxt_st.rdata[2:0]        = st_ff.pm;
          default:   nxt_st.rdata             = 32'h0000_0000;
        endcase
      end
    end

    nxt_st.irq    = |(nxt_st.stat & nxt_st.mask);
    nxt_st.halt   = (nxt_st.pm != TEI_PM_RUN);
    nxt_st.clk_en = (nxt_st.pm != TEI_PM_DOWN);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff.ctrl   <= CTRL_RST;
      st_ff.stat   <= STAT_RST;
      st_ff.mask   <= MASK_RST;
      st_ff.cnt_a  <= CNT_RST;
      st_ff.cnt_b  <= CNT_RST;
      st_ff.cnt_c  <= CNT_RST;
      st_ff.rcap_c <= CNT_RST;
      st_ff.pm     <= TEI_PM_RUN;
      st_ff.pend   <= 1'b0;
      st_ff.wr     <= 1'b0;
      st_ff.addr   <= 8'h00;
      st_ff.ready  <= 1'b1;
      st_ff.rdata  <= 32'h0000_0000;
      st_ff.irq    <= 1'b0;
      st_ff.halt   <= 1'b0;
      st_ff.clk_en <= 1'b1;
      st_ff.wake   <= 1'b0;
      st_ff.cout   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hrdata_o               = st_ff.rdata;
  assign hreadyout_o            = st_ff.ready;
  assign hresp_o                = 1'b0;
  assign irq_o                  = st_ff.irq;
  assign cpu_halt_o             = st_ff.halt;
  assign periph_clk_en_o        = st_ff.clk_en;
  assign wake_o                 = st_ff.wake;
  assign timer_c_clock_pin_o    = st_ff.cout;
  assign timer_c_clock_pin_oe_o = st_ff.ctrl[CB_C_CLKOUT];

endmodule : tei_timer_irq

// ==== dv/tei_pin_model.sv ====
// Purpose: Board-side model driving the external pins of the block
// Assumes: Pins are pulled up, so idle level is high
// Notes:   Every level is held three cycles, above the two-cycle minimum
`timescale 1ns/1ps
module tei_pin_model
  import tei_pkg::*;
(
  input  wire logic             clk_i, // System clock
  output logic      [PIN_W-1:0] pin_o  // Pin levels seen by the block
);
  import tei_pkg::*;

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // Pull-ups keep every pin high until the board pulls it down
  initial pin_o = PIN_RST;

  task automatic drive(input int i, input logic v);
    @(posedge clk_i);
    pin_o[i] <= v;
  endtask : drive

  task automatic pulse(input int i, input int n);
    repeat (n) begin
      drive(i, 1'b0);
      repeat (2) @(posedge clk_i);
      drive(i, 1'b1);
      repeat (2) @(posedge clk_i);
    end
  endtask : pulse
endmodule : tei_pin_model

// ==== dv/tei_timer_irq_chk.sv ====
// Purpose: Port-level assertions for the timer and irq block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the tei_timer_irq module at the foot of this file
`timescale 1ns/1ps
module tei_timer_irq_chk (
  input wire logic       clk_i,                  // Clock
  input wire logic       reset_i,                // Reset
  input wire logic       hsel_i,                 // Select
  input wire logic [1:0] htrans_i,               // Transfer type
  input wire logic       hready_i,               // Bus ready
  input wire logic       hreadyout_o,            // Slave ready
  input wire logic       hresp_o,                // Response
  input wire logic       ext_irq_a_pin_i,        // Irq pin A
  input wire logic       ext_irq_b_pin_i,        // Irq pin B
  input wire logic       timer_c_clock_pin_o,    // Clock pin out
  input wire logic       timer_c_clock_pin_oe_o, // Clock pin enable
  input wire logic       irq_o,                  // Interrupt
  input wire logic       cpu_halt_o,             // Halt
  input wire logic       periph_clk_en_o,        // Clock enable
  input wire logic       wake_o                  // Wake pulse
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  logic take;
  assign take = hsel_i && hready_i && htrans_i[1];

  a_bus_okay: assert property (hresp_o == 1'b0)
    else $error("response not OKAY");
  a_one_wait: assert property (
    take |=> !hreadyout_o ##1 hreadyout_o)
    else $error("wait state count wrong");
  a_wait_cause: assert property (
    !hreadyout_o |-> $past(take))
    else $error("wait without request");
  a_wake_single: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  a_wake_from_halt: assert property (
    wake_o |-> $past(cpu_halt_o) || $past(cpu_halt_o, 2))
    else $error("wake without halt");
  a_wake_resumes: assert property (
    wake_o |-> ##[0:1] !cpu_halt_o)
    else $error("halt kept after wake");
  a_down_halts: assert property (
    !periph_clk_en_o |-> cpu_halt_o)
    else $error("clock stopped without halt");
  // Irq fall in power-down must restart the clock quickly
  a_down_wakes: assert property (
    !periph_clk_en_o && ($fell(ext_irq_a_pin_i) || $fell(ext_irq_b_pin_i))
    |-> ##[1:8] periph_clk_en_o)
    else $error("no wake from power-down");
  a_clkout_drive: assert property (
    $changed(timer_c_clock_pin_o)
    |-> timer_c_clock_pin_oe_o || $past(timer_c_clock_pin_oe_o))
    else $error("clock pin moved while not driven");

  c_wake: cover property ($rose(wake_o));
  c_down: cover property ($fell(periph_clk_en_o));
  c_irq: cover property ($rose(irq_o));
  c_clkout: cover property ($fell(timer_c_clock_pin_o));
endmodule : tei_timer_irq_chk

bind tei_timer_irq tei_timer_irq_chk u_tei_timer_irq_chk (
  .clk_i, .reset_i, .hsel_i, .htrans_i, .hready_i, .hreadyout_o,
  .hresp_o, .ext_irq_a_pin_i, .ext_irq_b_pin_i, .timer_c_clock_pin_o,
  .timer_c_clock_pin_oe_o, .irq_o, .cpu_halt_o, .periph_clk_en_o, .wake_o);

// ==== dv/tei_timer_irq_tb_top.sv ====
// Purpose: Self-checking bench for the timer and irq block
// Assumes: One wait state per bus access, pins from the board model
// Notes:   Each scenario task drives and judges on its own
`timescale 1ns/1ps
module tei_timer_irq_tb_top;
  import tei_pkg::*;

  logic             clk_i, reset_i, hsel_i, hwrite_i;
  logic      [31:0] haddr_i, hwdata_i, hrdata_o;
  logic      [1:0]  htrans_i;
  logic      [2:0]  hsize_i;
  logic             hreadyout_o, hresp_o, c_out, c_oe, c_wire;
  logic             irq_o, cpu_halt_o, periph_clk_en_o, wake_o;
  logic [PIN_W-1:0] pins;
  int               n_errors = 0, total_checks = 0, n_wake = 0;

  // Shared clock pin: block drives it only while enabled
  assign c_wire = c_oe ? c_out : pins[PIN_CCLK];

  tei_pin_model u_tei_pin_model (.clk_i, .pin_o(pins));

  tei_timer_irq u_tei_timer_irq (
    .clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .ext_irq_a_pin_i(pins[PIN_IRQA]), .ext_irq_b_pin_i(pins[PIN_IRQB]),
    .timer_a_count_pin_i(pins[PIN_CNTA]),
    .timer_b_count_pin_i(pins[PIN_CNTB]),
    .timer_c_clock_pin_i(c_wire), .timer_c_clock_pin_o(c_out),
    .timer_c_clock_pin_oe_o(c_oe), .timer_c_ctrl_pin_i(pins[PIN_CCTL]),
    .irq_o, .cpu_halt_o, .periph_clk_en_o, .wake_o);

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Falling edge: outputs are settled, no race with their launch
  always @(negedge clk_i) if (wake_o === 1'b1) n_wake <= n_wake + 1;

  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    // Ready looked at mid-cycle; it stands until the next rising edge
    do @(negedge clk_i); while (hreadyout_o !== 1'b1);
    @(posedge clk_i);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(negedge clk_i); while (hreadyout_o !== 1'b1);
    // Data phase ends at the next rising edge, where the next call starts
    r = hrdata_o;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdc(OFF_PMODE, 32'h1);
    wr(OFF_CNTA, 32'h1FFFF);
    rdc(OFF_CNTA, 32'hFFFF);
    wr(8'h20, 32'hFF);
    rdc(8'h20, 32'h0);
    rdc(OFF_CTRL, 32'h0);
  endtask : t_regs

  task automatic t_edge;
    wr(OFF_CTRL, 32'hC0);
    for (int i = 0; i < 2; i++) begin
      wr(OFF_MASK, 32'h0);
      u_tei_pin_model.drive(i, 1'b0);
      cyc(6);
      chk(32'(irq_o), 32'h0);
      rdc(OFF_STAT, 32'h1 << i);
      wr(OFF_MASK, 32'h1 << i);
      cyc(2);
      chk(32'(irq_o), 32'h1);
      wr(OFF_STAT, 32'h1 << i);
      // Pin still low: edge mode must not set the flag again
      rdc(OFF_STAT, 32'h0);
      chk(32'(irq_o), 32'h0);
      u_tei_pin_model.drive(i, 1'b1);
      cyc(4);
    end
  endtask : t_edge

  task automatic t_level;
    wr(OFF_CTRL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      u_tei_pin_model.drive(i, 1'b0);
      cyc(4);
      wr(OFF_STAT, 32'h1 << i);
      rdc(OFF_STAT, 32'h1 << i);
      u_tei_pin_model.drive(i, 1'b1);
      cyc(4);
      wr(OFF_STAT, 32'h1 << i);
      rdc(OFF_STAT, 32'h0);
    end
  endtask : t_level

  task automatic t_count;
    wr(OFF_CTRL, 32'h2D);
    wr(OFF_CNTA, 32'h0);
    wr(OFF_CNTB, 32'h0);
    u_tei_pin_model.pulse(PIN_CNTA, 5);
    u_tei_pin_model.pulse(PIN_CNTB, 3);
    cyc(4);
    rdc(OFF_CNTA, 32'h5);
    rdc(OFF_CNTB, 32'h3);
  endtask : t_count

  task automatic t_gate;
    logic [31:0] v;
    for (int i = 0; i < 2; i++) begin
      u_tei_pin_model.drive(i, 1'b0);
      cyc(3);
      wr(OFF_CTRL, i ? 32'h18 : 32'h03);
      wr(OFF_CNTA + 8'(4 * i), 32'h0);
      cyc(5);
      rdc(OFF_CNTA + 8'(4 * i), 32'h0);
      u_tei_pin_model.drive(i, 1'b1);
      cyc(5);
      ahb(OFF_CNTA + 8'(4 * i), 1'b0, 32'h0, v);
      chk(32'(v != 32'h0), 32'h1);
    end
  endtask : t_gate

  task automatic t_clk_c;
    wr(OFF_CTRL, 32'h500);
    wr(OFF_CNTC, 32'hFFF0);
    cyc(30);
    chk(32'(c_oe), 32'h1);
    chk(32'(c_out), 32'h0);
    wr(OFF_CTRL, 32'h300);
    wr(OFF_CNTC, 32'h0);
    chk(32'(c_oe), 32'h0);
    u_tei_pin_model.pulse(PIN_CCLK, 4);
    cyc(4);
    rdc(OFF_CNTC, 32'h4);
  endtask : t_clk_c

  task automatic t_ctrl;
    wr(OFF_STAT, 32'h7F);
    wr(OFF_CTRL, 32'h1B00);
    wr(OFF_CNTC, 32'h1234);
    u_tei_pin_model.pulse(PIN_CCTL, 1);
    cyc(4);
    rdc(OFF_RCAPC, 32'h1234);
    rdc(OFF_STAT, 32'h20);
    wr(OFF_RCAPC, 32'h42);
    wr(OFF_CTRL, 32'h0B00);
    u_tei_pin_model.pulse(PIN_CCTL, 1);
    cyc(4);
    rdc(OFF_CNTC, 32'h42);
    wr(OFF_CTRL, 32'h2B00);
    wr(OFF_CNTC, 32'h10);
    u_tei_pin_model.pulse(PIN_CCLK, 1);
    cyc(4);
    rdc(OFF_CNTC, 32'h11);
    u_tei_pin_model.drive(PIN_CCTL, 1'b0);
    cyc(4);
    u_tei_pin_model.pulse(PIN_CCLK, 1);
    cyc(4);
    rdc(OFF_CNTC, 32'h10);
    u_tei_pin_model.drive(PIN_CCTL, 1'b1);
  endtask : t_ctrl

  task automatic t_sleep(input int down);
    logic [31:0] v0, v1;
    int w0;
    wr(OFF_STAT, 32'h7F);
    wr(OFF_MASK, down ? 32'h0 : 32'h1);
    wr(OFF_CTRL, down ? 32'h81 : 32'h41);
    wr(OFF_CNTA, 32'h0);
    w0 = n_wake;
    wr(OFF_PMODE, down ? 32'h2 : 32'h1);
    cyc(2);
    chk(32'(cpu_halt_o), 32'h1);
    chk(32'(periph_clk_en_o), down ? 32'h0 : 32'h1);
    ahb(OFF_CNTA, 1'b0, 32'h0, v0);
    cyc(5);
    ahb(OFF_CNTA, 1'b0, 32'h0, v1);
    // Timers advance in idle and stand still in power-down
    chk(32'(v1 != v0), down ? 32'h0 : 32'h1);
    u_tei_pin_model.drive(down, 1'b0);
    cyc(10);
    chk(32'(n_wake - w0), 32'h1);
    chk(32'(cpu_halt_o), 32'h0);
    chk(32'(periph_clk_en_o), 32'h1);
    rdc(OFF_STAT, down ? 32'h42 : 32'h41);
    u_tei_pin_model.drive(down, 1'b1);
    cyc(4);
  endtask : t_sleep

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #200us;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report;
  end

  initial begin
    reset_i  = 1'b1;
    hsel_i   = 1'b0;
    htrans_i = 2'h0;
    haddr_i  = 32'h0;
    hwrite_i = 1'b0;
    hsize_i  = 3'h2;
    hwdata_i = 32'h0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_edge();
    t_level();
    t_count();
    t_gate();
    t_clk_c();
    t_ctrl();
    t_sleep(0);
    t_sleep(1);
    final_report;
  end
endmodule : tei_timer_irq_tb_top
